// file: rtl/crd_atr_rom.sv
`timescale 1ns/100ps
// Answer-to-reset content; the check byte is supplied by the caller
module crd_atr_rom #(
	parameter logic [7:0]  OFFER_FD = crd_pkg::FD_512_16,
	parameter logic [7:0]  CDS_VAL  = 8'h00,
	parameter logic [23:0] CAP_VAL  = 24'h00_0000
) (
	input  wire logic [3:0] i_idx,
	input  wire logic [2:0] i_cls,
	output logic      [7:0] o_byte
);

	// Fixed layout keeps every answer of a session identical
	always_comb begin
		case (i_idx)
			crd_pkg::IX_TS:      o_byte = crd_pkg::TS_DIRECT;
			crd_pkg::IX_T0:      o_byte = crd_pkg::ATR_T0;
			crd_pkg::IX_TA1:     o_byte = OFFER_FD;             // [R9] [R8]
			crd_pkg::IX_TD1:     o_byte = crd_pkg::ATR_TD1;
			crd_pkg::IX_TD2:     o_byte = crd_pkg::ATR_TD2;     // [R5]
			crd_pkg::IX_TA3:     o_byte = {crd_pkg::CLK_STOP, 3'h0,
					i_cls};                                 // [R1] [R2]
			crd_pkg::IX_CAT:     o_byte = crd_pkg::HIST_CAT;    // [R6]
			crd_pkg::IX_CDS_TAG: o_byte = crd_pkg::TAG_CDS;     // [R7]
			crd_pkg::IX_CDS:     o_byte = CDS_VAL;
			crd_pkg::IX_CAP_TAG: o_byte = crd_pkg::TAG_CAP;     // [R7]
			crd_pkg::IX_CAP0:    o_byte = CAP_VAL[23:16];
			crd_pkg::IX_CAP1:    o_byte = CAP_VAL[15:8];
			crd_pkg::IX_CAP2:    o_byte = CAP_VAL[7:0];
			default:             o_byte = 8'h00;
		endcase
	end

endmodule : crd_atr_rom

// file: rtl/crd_card.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Card end: reset classification, answer to reset, parameter selection,
// security status and application-selected tracking.
////////////////////////////////////////////////////////////////////////////

// Operation
// (R1) Card flags classes A, B, C in bits 0-2
// (R2) Class D and E bits are never usable
// (R3) Indicated classes must be adjacent, never A+C
// (R4) Terminal skips foreign interface, historical, check bytes
// (R5) Answer always carries the global T=15 group
// (R6) First historical byte is category 80
// (R7) Then card data tag 31, capabilities 73
// (R8) Both support 512/8, 512/16 and 372/1
// (R9) Offered F and D sit in TA1
// (R10) Non-default speed only after a completed PPS
// (R11) Terminal requests only values the card offered
// (R12) First reset is cold, later ones warm
// (R13) Cold reset: negotiable mode, security status cleared
// (R14) Warm reset: specific mode keeps protocol, Fi/Di
// (R15) Every warm reset gives an identical answer
// (R16) Warm reset also clears the security status
// (R17) Selected once access verified, or command executed
// (R18) Select plus status query does not select
// (R19) Terminal reads power need from select/status
// (R20) Start lowest class; no answer: next class up
// (R21) Corrupt answer: three tries, then next class
// (R22) Flag remembers a reset since activation
module crd_card #(
	parameter logic [7:0]  OFFER_FD = crd_pkg::FD_512_16,
	parameter logic [7:0]  CDS_VAL  = 8'h00,
	parameter logic [23:0] CAP_VAL  = 24'h00_0000
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	crd_link_if.card        lnk,
	input  wire logic [2:0] i_classes,
	input  wire logic       i_warm_specific,
	input  wire logic       i_app_select,
	input  wire logic       i_ac_needed,
	input  wire logic       i_verify_ok,
	input  wire logic       i_cmd_exec,
	input  wire logic       i_cmd_is_status,
	output logic            o_cold,
	output logic            o_warm,
	output logic            o_negotiable,
	output logic      [7:0] o_fi_di,
	output logic      [2:0] o_classes,
	output logic            o_sec_ok,
	output logic            o_app_selected,
	output logic            o_running
);

	////////////////////////////////////////////////////////////////////////
	// Types and state

	typedef enum logic [2:0] {
		CS_OFF,
		CS_RST,
		CS_GAP,
		CS_ATR,
		CS_NEG,
		CS_PPS_RX,
		CS_PPS_TX,
		CS_RUN
	} crd_cst_type;

	typedef struct packed {
		crd_cst_type     st;
		logic            seen;
		logic            cold;
		logic            warm;
		logic            neg;
		logic [2:0]      cls;
		logic [7:0]      fd;
		logic [7:0]      fd_req;
		logic [3:0]      idx;
		logic [7:0]      acc;
		logic            tx_vld;
		logic [7:0]      tx_data;
		logic            sec;
		logic            app;
		logic [3:0][7:0] pps;
	} crd_card_state_type;

	localparam crd_card_state_type CARD_RST = '{
		st:      CS_OFF,
		fd:      crd_pkg::FD_DEF,
		default: '0
	};

	crd_card_state_type st;
	crd_card_state_type nx;
	logic [7:0]         rom_byte;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// A gapped or empty strap falls back to class A alone, since
	// indicating a class set with a hole is never allowed
	function automatic logic [2:0] cls_fix(input logic [2:0] m);
		if (m == crd_pkg::CLS_GAP_AC || m == 3'h0) begin
			cls_fix = crd_pkg::CLS_A;
		end else begin
			cls_fix = m;
		end
	endfunction : cls_fix

	// Request is well formed, within the offer and checksums to zero
	function automatic logic pps_ok(input logic [3:0][7:0] p);
		pps_ok = (p[0] == crd_pkg::PPSS) && (p[1] == crd_pkg::PPS0_T0) &&
			crd_pkg::fd_in_range(p[2], OFFER_FD) &&
			((p[0] ^ p[1] ^ p[2] ^ p[3]) == 8'h00);
	endfunction : pps_ok

	////////////////////////////////////////////////////////////////////////
	// Answer content, addressed by the byte counter

	crd_atr_rom #(
		.OFFER_FD (OFFER_FD),
		.CDS_VAL  (CDS_VAL),
		.CAP_VAL  (CAP_VAL)
	) u_rom (
		.i_idx  (st.idx),
		.i_cls  (st.cls),
		.o_byte (rom_byte)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic [3:0][7:0] pv;
		pv = st.pps;
		nx = st;
		nx.cold = 1'b0;
		nx.warm = 1'b0;
		nx.tx_vld = 1'b0;
		case (st.st)
			CS_OFF: begin
				if (lnk.vcc_on) begin
					nx.st = CS_RST;
				end
			end
			// Classify on the release of reset
			CS_RST: begin
				if (!lnk.rst) begin
					nx.seen = 1'b1;                             // [R22]
					nx.idx = 4'h0;
					nx.st = CS_GAP;
					if (!st.seen) begin
						nx.cold = 1'b1;                         // [R12]
						nx.neg = 1'b1;                          // [R13]
						nx.fd = crd_pkg::FD_DEF;
						// Strap is caught once per session only
						nx.cls = cls_fix(i_classes);            // [R3] [R15]
					end else begin
						nx.warm = 1'b1;                         // [R12]
						nx.neg = !i_warm_specific;              // [R14]
						if (!i_warm_specific) begin
							nx.fd = crd_pkg::FD_DEF;
						end
					end
				end
			end
			CS_GAP: begin
				nx.idx = st.idx + 4'h1;
				if (st.idx == crd_pkg::ATR_GAP - 4'h1) begin
					nx.idx = 4'h0;
					nx.st = CS_ATR;
				end
			end
			// One byte a cycle; the check byte closes the answer
			CS_ATR: begin
				nx.tx_vld = 1'b1;
				nx.tx_data = (st.idx == crd_pkg::IX_TCK) ? st.acc : rom_byte;
				nx.acc = (st.idx == crd_pkg::IX_TS) ? 8'h00 :
					st.acc ^ rom_byte;
				nx.idx = st.idx + 4'h1;
				if (st.idx == crd_pkg::IX_TCK) begin
					nx.idx = 4'h0;
					nx.st = st.neg ? CS_NEG : CS_RUN;           // [R14]
				end
			end
			// Only the first byte may open a selection
			CS_NEG: begin
				if (lnk.t2c_vld) begin
					if (lnk.t2c_data == crd_pkg::PPSS) begin
						nx.pps[0] = lnk.t2c_data;
						nx.idx = 4'h1;
						nx.st = CS_PPS_RX;
					end else begin
						nx.neg = 1'b0;                          // [R10]
						nx.st = CS_RUN;
					end
				end
			end
			CS_PPS_RX: begin
				if (lnk.t2c_vld) begin
					pv[st.idx[1:0]] = lnk.t2c_data;
					nx.pps = pv;
					nx.idx = st.idx + 4'h1;
					if (st.idx == crd_pkg::PPS_LAST) begin
						nx.idx = 4'h0;
						nx.fd_req = pv[2];
						// A bad request gets silence and keeps defaults
						nx.st = pps_ok(pv) ? CS_PPS_TX : CS_RUN; // [R8]
						nx.neg = pps_ok(pv);
					end
				end
			end
			// Echo confirms; the new factors apply in the cycle its last byte goes out
			CS_PPS_TX: begin
				nx.tx_vld = 1'b1;
				nx.tx_data = st.pps[st.idx[1:0]];
				nx.idx = st.idx + 4'h1;
				if (st.idx == crd_pkg::PPS_LAST) begin
					nx.fd = st.fd_req;                          // [R10]
					nx.neg = 1'b0;
					nx.st = CS_RUN;
				end
			end
			CS_RUN: begin
				nx.neg = 1'b0;
			end
			default: begin
				nx.st = CS_OFF;
			end
		endcase

		// Session events; sets are placed after clears so they win
		if (st.st == CS_RUN) begin
			if (i_app_select) begin
				nx.app = 1'b0;
			end
			if (i_verify_ok) begin
				nx.sec = 1'b1;
			end
			if (i_verify_ok && i_ac_needed) begin
				nx.app = 1'b1;                                  // [R17]
			end
			if (i_cmd_exec && !i_cmd_is_status && !i_ac_needed) begin
				nx.app = 1'b1;                                  // [R17] [R18]
			end
		end

		// Any reset wipes the security status and the selection
		if (lnk.rst && st.st != CS_OFF) begin
			nx.st = CS_RST;
			nx.sec = 1'b0;                                      // [R13] [R16]
			nx.app = 1'b0;
			nx.idx = 4'h0;
		end

		// Deactivation ends the session; next reset will be cold
		if (!lnk.vcc_on) begin
			nx.st = CS_OFF;
			nx.seen = 1'b0;                                     // [R22]
			nx.sec = 1'b0;
			nx.app = 1'b0;
			nx.neg = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= CARD_RST;
		end else begin
			st <= nx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Link data leaves straight from flip-flops
	assign lnk.c2t_vld    = st.tx_vld;
	assign lnk.c2t_data   = st.tx_data;
	assign o_cold         = st.cold;
	assign o_warm         = st.warm;
	assign o_negotiable   = st.neg;
	assign o_fi_di        = st.fd;
	assign o_classes      = st.cls;
	assign o_sec_ok       = st.sec;
	assign o_app_selected = st.app;
	assign o_running      = (st.st == CS_RUN);

endmodule : crd_card

// file: rtl/crd_link_if.sv
`timescale 1ns/100ps
// Contact-level link at byte granularity; character framing lies outside
interface crd_link_if;
	logic       vcc_on;
	logic [2:0] vcc_cls;
	logic       rst;
	logic       t2c_vld;
	logic [7:0] t2c_data;
	logic       c2t_vld;
	logic [7:0] c2t_data;

	modport card (
		input  vcc_on, vcc_cls, rst, t2c_vld, t2c_data,
		output c2t_vld, c2t_data
	);
	modport term (
		output vcc_on, vcc_cls, rst, t2c_vld, t2c_data,
		input  c2t_vld, c2t_data
	);
endinterface : crd_link_if

// file: rtl/crd_pkg.sv
package crd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Supply voltage classes, one bit each in the class field
	localparam logic [2:0] CLS_A      = 3'h1;
	localparam logic [2:0] CLS_B      = 3'h2;
	localparam logic [2:0] CLS_C      = 3'h4;
	localparam logic [2:0] CLS_GAP_AC = 3'h5;
	localparam logic [4:0] CLS_RFU    = 5'h18;
	localparam logic [1:0] CLK_STOP   = 2'h1;

	////////////////////////////////////////////////////////////////////////
	// Answer-to-reset byte values
	localparam logic [7:0] TS_DIRECT  = 8'h3B;
	localparam logic [7:0] TS_INVERSE = 8'h3F;
	localparam logic [7:0] ATR_T0     = 8'h97;
	localparam logic [7:0] ATR_TD1    = 8'h80;
	localparam logic [7:0] ATR_TD2    = 8'h1F;
	localparam logic [3:0] T_GLOBAL   = 4'hF;
	localparam logic [7:0] HIST_CAT   = 8'h80;
	localparam logic [7:0] TAG_CDS    = 8'h31;
	localparam logic [7:0] TAG_CAP    = 8'h73;

	////////////////////////////////////////////////////////////////////////
	// Byte positions inside the answer to reset
	localparam logic [3:0] IX_TS      = 4'h0;
	localparam logic [3:0] IX_T0      = 4'h1;
	localparam logic [3:0] IX_TA1     = 4'h2;
	localparam logic [3:0] IX_TD1     = 4'h3;
	localparam logic [3:0] IX_TD2     = 4'h4;
	localparam logic [3:0] IX_TA3     = 4'h5;
	localparam logic [3:0] IX_CAT     = 4'h6;
	localparam logic [3:0] IX_CDS_TAG = 4'h7;
	localparam logic [3:0] IX_CDS     = 4'h8;
	localparam logic [3:0] IX_CAP_TAG = 4'h9;
	localparam logic [3:0] IX_CAP0    = 4'hA;
	localparam logic [3:0] IX_CAP1    = 4'hB;
	localparam logic [3:0] IX_CAP2    = 4'hC;
	localparam logic [3:0] IX_TCK     = 4'hD;

	////////////////////////////////////////////////////////////////////////
	// Transmission factors and parameter selection
	localparam logic [7:0] FD_DEF     = 8'h11;
	localparam logic [7:0] FD_512_8   = 8'h94;
	localparam logic [7:0] FD_512_16  = 8'h95;
	localparam logic [7:0] PPSS       = 8'hFF;
	localparam logic [7:0] PPS0_T0    = 8'h10;
	localparam logic [3:0] PPS_LAST   = 4'h3;
	localparam logic [1:0] ATR_TRIES  = 2'h3;
	localparam logic [3:0] ATR_GAP    = 4'h2;

	////////////////////////////////////////////////////////////////////////
	// Timing: least times round up, longest times round down
	localparam int CLK_MHZ     = 125;
	localparam int T_RST_NS    = 1000;
	localparam int RST_CYC     = (T_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int T_ATR_TO_NS = 40000;
	localparam int ATR_TO_CYC  = (T_ATR_TO_NS * CLK_MHZ) / 1000;
	localparam int T_PPS_TO_NS = 2000;
	localparam int PPS_TO_CYC  = (T_PPS_TO_NS * CLK_MHZ) / 1000;

	// Mandatory pairs always pass; others must not exceed the offer
	function automatic logic fd_in_range(input logic [7:0] req,
			input logic [7:0] offer);
		fd_in_range = (req == FD_DEF) || (req == FD_512_8) ||
			(req == FD_512_16) || ((req[7:4] == offer[7:4]) &&
			(req[3:0] != 4'h0) && (req[3:0] <= offer[3:0]));
	endfunction : fd_in_range

endpackage : crd_pkg

// file: rtl/crd_term.sv
`timescale 1ns/100ps
// Terminal end: activation with class search, answer parsing,
// parameter selection and warm reset
module crd_term #(
	parameter int ATR_TO = crd_pkg::ATR_TO_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	crd_link_if.term        lnk,
	input  wire logic       i_activate,
	input  wire logic       i_deactivate,
	input  wire logic       i_warm_rst,
	input  wire logic [2:0] i_term_classes,
	input  wire logic       i_pps_en,
	input  wire logic [7:0] i_pps_fd,
	input  wire logic       i_sel_pwr_vld,
	input  wire logic       i_stat_pwr_vld,
	input  wire logic [7:0] i_pwr,
	output logic            o_ready,
	output logic            o_reject,
	output logic      [2:0] o_class,
	output logic      [2:0] o_card_classes,
	output logic      [7:0] o_fi_di,
	output logic      [7:0] o_app_pwr,
	output logic      [1:0] o_bad_cnt
);

	typedef enum logic [3:0] {
		TS_IDLE, TS_PWR, TS_RX, TS_DOWN, TS_PPS_TX, TS_PPS_RX, TS_RUN, TS_REJ
	} crd_tst_type;

	typedef struct packed {
		crd_tst_type     st;
		logic            vcc;
		logic            rst;
		logic [2:0]      cls;
		logic [2:0]      ccls;
		logic            cseen;
		logic [7:0]      fd;
		logic [7:0]      ta1;
		logic [15:0]     cnt;
		logic [1:0]      ph;
		logic [3:0]      pend;
		logic [3:0]      hist;
		logic            grp1;
		logic            t15;
		logic            tck;
		logic            err;
		logic [7:0]      acc;
		logic [1:0]      bad;
		logic [3:0]      idx;
		logic            tx_vld;
		logic [7:0]      tx_data;
		logic [3:0][7:0] pps;
		logic [7:0]      pwr;
	} crd_term_state_type;

	crd_term_state_type st;
	crd_term_state_type nx;

	// Lowest supply voltage first: C, then B, then A
	function automatic logic [2:0] cls_low(input logic [2:0] m);
		if (m[2]) cls_low = crd_pkg::CLS_C;
		else if (m[1]) cls_low = crd_pkg::CLS_B;
		else if (m[0]) cls_low = crd_pkg::CLS_A;
		else cls_low = 3'h0;
	endfunction : cls_low

	// Next higher supported class, or none
	function automatic logic [2:0] cls_next(input logic [2:0] c,
			input logic [2:0] sup);
		if (c == crd_pkg::CLS_C) cls_next = cls_low(sup & 3'h3);
		else if (c == crd_pkg::CLS_B) cls_next = sup & crd_pkg::CLS_A;
		else cls_next = 3'h0;
	endfunction : cls_next

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic [7:0] d;
		logic [2:0] c;
		logic [2:0] rcls;
		logic       fin;
		logic       good;
		logic       quiet;
		logic       tckb;
		logic       retry;
		d = lnk.c2t_data;
		c = 3'h0;
		rcls = 3'h0;
		fin = 1'b0;
		good = 1'b0;
		quiet = 1'b0;
		tckb = 1'b0;
		retry = 1'b0;
		nx = st;
		nx.tx_vld = 1'b0;
		nx.cnt = st.cnt + 16'h1;
		case (st.st)
			TS_IDLE: begin
				nx.cnt = 16'h0;
				if (i_activate) begin
					nx.cls = cls_low(i_term_classes);           // [R20]
					nx.bad = 2'h0;
					nx.fd = crd_pkg::FD_DEF;
					nx.st = (nx.cls == 3'h0) ? TS_REJ : TS_PWR;
				end
			end
			TS_PWR, TS_DOWN: begin
				if (st.cnt == 16'(crd_pkg::RST_CYC - 1)) begin
					nx.cnt = 16'h0;
					nx.st = (st.st == TS_PWR) ? TS_RX : TS_PWR;
					{nx.ph, nx.pend, nx.hist, nx.tck} = '0;
					{nx.err, nx.cseen, nx.t15, nx.acc} = '0;
					nx.ta1 = crd_pkg::FD_DEF;
				end
			end
			TS_RX: begin
				if (lnk.c2t_vld) begin
					nx.cnt = 16'h0;
					if (st.ph == 2'h0) begin
						nx.ph = 2'h1;
						nx.err = (d != crd_pkg::TS_DIRECT) &&
							(d != crd_pkg::TS_INVERSE);
					end else begin
						nx.acc = st.acc ^ d;
						if (st.ph == 2'h1) begin
							nx.ph = 2'h2;
							{nx.pend, nx.hist} = d;
							nx.grp1 = 1'b1;
						end else if (st.pend != 4'h0) begin
							if (st.pend[0] && st.grp1) nx.ta1 = d;
							if (st.pend[0] && st.t15 && !st.cseen) begin
								nx.ccls = d[2:0];                 // [R2]
								nx.cseen = 1'b1;
							end
							if (st.pend == 4'h8) begin
								nx.pend = d[7:4];
								nx.grp1 = 1'b0;
								nx.t15 = (d[3:0] == crd_pkg::T_GLOBAL);
								if (d[3:0] != 4'h0) nx.tck = 1'b1;
							end else begin
								nx.pend = st.pend & (st.pend - 4'h1); // [R4]
							end
						end else if (st.hist != 4'h0) begin
							nx.hist = st.hist - 4'h1;           // [R4]
						end else begin
							tckb = 1'b1;                        // [R4]
						end
					end
					fin = tckb || (nx.ph == 2'h2 && nx.pend == 4'h0 &&
						nx.hist == 4'h0 && !nx.tck);
					good = !nx.err && (!tckb || nx.acc == 8'h00);
				end else if (st.cnt == 16'(ATR_TO - 1)) begin
					fin = 1'b1;
					quiet = (st.ph == 2'h0);
				end
			end
			TS_PPS_TX: begin
				nx.tx_vld = 1'b1;
				nx.tx_data = st.pps[st.idx[1:0]];
				nx.idx = st.idx + 4'h1;
				if (st.idx == crd_pkg::PPS_LAST) begin
					{nx.idx, nx.cnt, nx.err} = '0;
					nx.st = TS_PPS_RX;
				end
			end
			// Factors change only on a full matching echo
			TS_PPS_RX: begin
				if (lnk.c2t_vld) begin
					nx.idx = st.idx + 4'h1;
					nx.err = st.err || (d != st.pps[st.idx[1:0]]);
					if (st.idx == crd_pkg::PPS_LAST) begin
						if (!nx.err) nx.fd = st.pps[2];         // [R10]
						nx.st = TS_RUN;
					end
				end else if (st.cnt == 16'(crd_pkg::PPS_TO_CYC - 1)) begin
					nx.st = TS_RUN;
				end
			end
			TS_RUN: begin
				if (i_sel_pwr_vld || i_stat_pwr_vld) nx.pwr = i_pwr; // [R19]
				if (i_warm_rst) begin
					nx.cnt = 16'h0;
					nx.st = TS_PWR;
				end
			end
			TS_REJ: begin
				nx.cnt = 16'h0;
			end
			default: nx.st = TS_IDLE;
		endcase

		// Outcome of one answer: go on, retry here, or move up a class
		if (fin) begin
			c = st.cseen ? (nx.ccls & crd_pkg::CLS_C | nx.ccls &
				crd_pkg::CLS_B | nx.ccls & crd_pkg::CLS_A) : crd_pkg::CLS_A;
			if (good) begin
				nx.bad = 2'h0;
				nx.ccls = c;
				if ((c & st.cls) != 3'h0) begin
					nx.idx = 4'h0;
					nx.pps[0] = crd_pkg::PPSS;
					nx.pps[1] = crd_pkg::PPS0_T0;
					nx.pps[2] = i_pps_fd;
					nx.pps[3] = crd_pkg::PPSS ^ crd_pkg::PPS0_T0 ^ i_pps_fd;
					nx.st = (i_pps_en && i_pps_fd != crd_pkg::FD_DEF &&
						crd_pkg::fd_in_range(i_pps_fd, nx.ta1)) ?
						TS_PPS_TX : TS_RUN;                     // [R11]
				end else begin
					retry = 1'b1;
					rcls = cls_low(c & i_term_classes);
				end
			end else if (quiet) begin
				retry = 1'b1;
				rcls = cls_next(st.cls, i_term_classes);        // [R20]
			end else if (st.bad == crd_pkg::ATR_TRIES - 2'h1) begin
				retry = 1'b1;
				nx.bad = 2'h0;
				rcls = cls_next(st.cls, i_term_classes);        // [R21]
			end else begin
				retry = 1'b1;
				nx.bad = st.bad + 2'h1;                         // [R21]
				rcls = st.cls;
			end
		end
		if (retry) begin
			nx.cls = rcls;
			nx.cnt = 16'h0;
			nx.st = (rcls == 3'h0) ? TS_REJ : TS_DOWN;
		end
		if (i_deactivate) nx.st = TS_IDLE;

		// Supply follows the next state; reset held while powering
		nx.vcc = (nx.st != TS_IDLE) && (nx.st != TS_DOWN) &&
			(nx.st != TS_REJ);
		nx.rst = (nx.st == TS_PWR) || !nx.vcc;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign lnk.vcc_on   = st.vcc;
	assign lnk.vcc_cls  = st.cls;
	assign lnk.rst      = st.rst;
	assign lnk.t2c_vld  = st.tx_vld;
	assign lnk.t2c_data = st.tx_data;
	assign o_ready        = (st.st == TS_RUN);
	assign o_reject       = (st.st == TS_REJ);
	assign o_class        = st.cls;
	assign o_card_classes = st.ccls;
	assign o_fi_di        = st.fd;
	assign o_app_pwr      = st.pwr;
	assign o_bad_cnt      = st.bad;

endmodule : crd_term

// file: tb/card_answer_to_reset_logic_test.sv
`timescale 1ns/100ps
// Terminal and card ends joined over one link; user sides driven here
module card_answer_to_reset_logic_test;
	logic         i_clk_sys, i_sys_rst, spec, acn, stq, ppe, c_cold, c_warm;
	logic         c_neg, c_sec, c_app, t_rdy, t_rej, c_run;
	logic [7:0]   e_cold = 8'h00;
	logic [2:0]   strap, c_cls, t_cls, t_ccls, a;
	logic [7:0]   pl, fd, pwr, c_fd, t_fd, t_pwr;
	logic [7:0]   n_cold = 8'h00, n_warm = 8'h00, idx = 8'h00;
	logic [7:0]   fds [3] = '{8'h11, 8'h94, 8'h95};
	logic [2:0]   sts [5] = '{3'h5, 3'h6, 3'h3, 3'h1, 3'h2};
	logic [111:0] atr, snap;
	logic [31:0]  rnd = 32'h0000_3b21;
	int           n_mismatch = 0, checks_done = 0, cyc = 0;
	crd_link_if lnk ();

	// Pulse bits: 0 act, 1 deact, 2 warm, 3 sel, 4 verify, 5 cmd, 6/7 power
	crd_card crd_card_i (.i_clk_sys, .i_sys_rst, .lnk, .i_classes(strap),
		.i_warm_specific(spec), .i_app_select(pl[3]), .i_ac_needed(acn),
		.i_verify_ok(pl[4]), .i_cmd_exec(pl[5]), .i_cmd_is_status(stq),
		.o_cold(c_cold), .o_warm(c_warm), .o_negotiable(c_neg),
		.o_fi_di(c_fd), .o_classes(c_cls), .o_sec_ok(c_sec),
		.o_app_selected(c_app), .o_running(c_run));
	crd_term #(.ATR_TO(300)) crd_term_i (.i_clk_sys, .i_sys_rst, .lnk,
		.i_activate(pl[0]), .i_deactivate(pl[1]), .i_warm_rst(pl[2]),
		.i_term_classes(3'h7), .i_pps_en(ppe), .i_pps_fd(fd),
		.i_sel_pwr_vld(pl[6]), .i_stat_pwr_vld(pl[7]), .i_pwr(pwr),
		.o_ready(t_rdy), .o_reject(t_rej), .o_class(t_cls),
		.o_card_classes(t_ccls), .o_fi_di(t_fd), .o_app_pwr(t_pwr),
		.o_bad_cnt());
	crd_monitor crd_monitor_i (.i_clk_sys, .i_sys_rst,
		.vcc_on(lnk.vcc_on), .vcc_cls(lnk.vcc_cls), .rst(lnk.rst),
		.t2c_vld(lnk.t2c_vld), .t2c_data(lnk.t2c_data),
		.c2t_vld(lnk.c2t_vld), .c2t_data(lnk.c2t_data));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction : xs
	// Gapped or empty straps fall back to class A alone
	function automatic logic [2:0] ann(input logic [2:0] s);
		ann = (s == 3'h5 || s == 3'h0) ? 3'h1 : s;
	endfunction : ann

	task automatic chk(input string nm, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Extra edge at the end keeps two pulses from meeting in one step
	task automatic pulse(input int b);
		pl[b] <= 1'b1;
		@(posedge i_clk_sys);
		pl[b] <= 1'b0;
		@(posedge i_clk_sys);
	endtask : pulse
	task automatic wait_rdy();
		for (int k = 0; k < 3000; k++) begin
			@(negedge i_clk_sys);
			if (t_rdy === 1'b1) break;
		end
		@(posedge i_clk_sys);
	endtask : wait_rdy
	task automatic complete_run();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end

	// Classification counts, answer capture and the hang limit
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (c_cold === 1'b1) n_cold <= n_cold + 8'h01;
		if (c_warm === 1'b1) n_warm <= n_warm + 8'h01;
		if (c_cold === 1'b1) chk("cold mode", 8'h01, {7'h0, c_neg});
		if (lnk.rst === 1'b1) idx <= 8'h00;
		else if (lnk.c2t_vld === 1'b1 && idx < 8'h0E) begin
			atr <= {atr[103:0], lnk.c2t_data};
			idx <= idx + 8'h01;
		end
		if (cyc == 30000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		{pl, spec, acn, stq, pwr, fd, strap} = '0;
		ppe = 1'b1;
		i_sys_rst = 1'b1;
		repeat (8) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		// Cold activations over class straps, gapped one first
		for (int i = 0; i < 6; i++) begin
			rnd = xs(rnd);
			strap <= (i < 5) ? sts[i] : sts[rnd % 5];
			// Last speed is non-default so the card leaves negotiable mode
			fd <= (i < 3) ? fds[i] : fds[1 + rnd[8]];
			pulse(1);
			pulse(0);
			wait_rdy();
			a = ann(strap);
			e_cold = e_cold + (a[2] ? 8'h01 : 8'h02); // No class C: one retry
			chk("card classes", {5'h0, a}, {5'h0, c_cls});
			chk("parsed classes", {5'h0, a}, {5'h0, t_ccls});
			chk("class", a[2] ? 8'h4 : a[1] ? 8'h2 : 8'h1, {5'h0, t_cls});
			chk("reject", 8'h00, {7'h0, t_rej});
			chk("term speed", fd, t_fd);
			chk("card speed", fd, c_fd);
			chk("cold count", e_cold, n_cold);
			chk("negotiable", {7'h0, fd == crd_pkg::FD_DEF},
				{7'h0, c_neg});
		end
		// Session: verify, status query, plain command, power capture
		chk("card running", 8'h01, {7'h0, c_run});
		acn <= 1'b1;
		pulse(4);
		chk("sel verify", 8'h01, {7'h0, c_app});
		acn <= 1'b0;
		stq <= 1'b1;
		pulse(3);
		pulse(5);
		chk("sel status", 8'h00, {7'h0, c_app});
		stq <= 1'b0;
		pulse(5);
		chk("sel command", 8'h01, {7'h0, c_app});
		pwr <= rnd[7:0];
		pulse(6);
		chk("select power", rnd[7:0], t_pwr);
		pwr <= rnd[15:8];
		pulse(7);
		chk("status power", rnd[15:8], t_pwr);
		// Warm resets, negotiable then specific, answer must not move
		for (int k = 0; k < 2; k++) begin
			chk("sec before warm", 8'h01, {7'h0, c_sec});
			spec <= k[0];
			pulse(2);
			wait_rdy();
			if (k == 0) snap = atr;
			chk("warm count", 8'(k + 1), n_warm);
			chk("sec after warm", 8'h00, {7'h0, c_sec});
			chk("speed kept", fd, c_fd);
			pulse(4);
		end
		chk("warm answer", 8'h00, {7'h0, snap !== atr});
		chk("category", crd_pkg::HIST_CAT, snap[63:56]);
		complete_run();
	end
endmodule : card_answer_to_reset_logic_test

// file: tb/crd_monitor.sv
`timescale 1ns/100ps
// Watches the link between the terminal and card ends
module crd_monitor #(
	parameter logic [7:0] OFFER_FD = crd_pkg::FD_512_16
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	input  wire logic       vcc_on,
	input  wire logic [2:0] vcc_cls,
	input  wire logic       rst,
	input  wire logic       t2c_vld,
	input  wire logic [7:0] t2c_data,
	input  wire logic       c2t_vld,
	input  wire logic [7:0] c2t_data
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);

	// First answer byte after silence; a mid-stream 3B is not a start
	sequence atr_go;
		c2t_vld && c2t_data == crd_pkg::TS_DIRECT && !$past(c2t_vld);
	endsequence

	////////////////////////////////////////////////////////////////////////
	a_answer_after_rst: assert property (
		$fell(rst) && vcc_on |-> ##[1:8] atr_go)
		else $error("no answer after reset release");
	a_global_group: assert property (
		atr_go |-> ##3 c2t_data == crd_pkg::ATR_TD1
		##1 c2t_data[3:0] == crd_pkg::T_GLOBAL)
		else $error("global group missing");
	a_class_field: assert property (
		atr_go |-> ##5 c2t_data[4:0] inside {5'h01, 5'h02, 5'h04,
		5'h03, 5'h06, 5'h07})
		else $error("bad class field");
	a_hist_objects: assert property (
		atr_go |-> ##6 c2t_data == crd_pkg::HIST_CAT
		##1 c2t_data == crd_pkg::TAG_CDS ##2 c2t_data == crd_pkg::TAG_CAP)
		else $error("historical bytes out of order");
	a_offer_byte: assert property (
		atr_go |-> ##2 c2t_data == OFFER_FD)
		else $error("speed offer wrong");
	a_pps_in_range: assert property (
		t2c_vld && $past(t2c_vld) && $past(t2c_data) == crd_pkg::PPS0_T0
		|-> crd_pkg::fd_in_range(t2c_data, OFFER_FD))
		else $error("speed request outside offer");
	a_class_steady: assert property (
		vcc_on && $past(vcc_on) |-> $stable(vcc_cls))
		else $error("class changed while powered");
	a_class_onehot: assert property (
		vcc_on |-> vcc_cls inside {3'h1, 3'h2, 3'h4})
		else $error("applied class not single");

	// Main scenarios reached
	c_answer: cover property (atr_go);
	c_class_a: cover property ($rose(vcc_on) && vcc_cls == 3'h1);
	c_pps: cover property (t2c_vld && t2c_data == crd_pkg::PPSS);
endmodule : crd_monitor
